// ===== logic/composite_clock_rx_tx.sv
// composite clock top: two receivers, sticky alarm status, interrupt and the transmitter
`timescale 1ns/10ps
module composite_clock_rx_tx import cc_pkg::*; #(
  parameter int NO8_CYC = NO8_DEF_CYC,
  parameter int NO4_CYC = NO4_DEF_CYC
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  // receive pins, asynchronous
  input  wire logic       cc_receive_pin_one_pos_in,
  input  wire logic       cc_receive_pin_one_neg_in,
  input  wire logic       cc_receive_pin_two_pos_in,
  input  wire logic       cc_receive_pin_two_neg_in,
  input  wire logic       input_clock_one_in,
  input  wire logic       input_clock_two_in,
  // receiver configuration
  input  wire logic [1:0] chan_signal_format_in,
  input  wire logic       chan_signal_format_load_in,
  input  wire logic       recovered_edge_select_in,
  input  wire logic       single_bit_error_count_en_in,
  input  wire logic       ami_invalidate_en_in,
  input  wire logic       los_invalidate_en_in,
  // status clear strobes and interrupt enables
  input  wire logic [3:0] line_alarm_clear_in,
  input  wire logic [3:0] line_alarm_irq_enable_in,
  input  wire logic [3:0] component_missing_clear_in,
  input  wire logic [3:0] component_missing_irq_enable_in,
  // transmitter configuration
  input  wire logic       cc_transmit_enable_in,
  input  wire logic       cc_transmit_duty_select_in,
  input  wire logic       cc_transmit_suppress_8k_in,
  input  wire logic       cc_transmit_400hz_enable_in,
  input  wire logic [1:0] reference_select_in,
  // receiver results
  output logic [1:0]      chan_signal_format_out,
  output logic            input_clock_one_out,
  output logic            input_clock_two_out,
  output logic [1:0]      clock_invalid_out,
  output logic [1:0]      irregularity_out,
  // status and interrupt
  output logic [3:0]      line_alarm_status_out,
  output logic [3:0]      component_missing_status_out,
  output logic            interrupt_request_pin_out,
  // transmit pair
  output logic            cc_transmit_positive_out,
  output logic            cc_transmit_negative_out,
  output logic            cc_transmit_oe_out
);
  typedef struct packed {
    logic [1:0]      fmt;
    logic [3:0]      la_stat;
    logic [3:0]      cm_stat;
    logic            irq;
    logic [ACC_W-1:0] acc;
    logic [2:0]      bit_idx;
    logic [4:0]      frame;
    logic            pol;
    logic            pulse;
    logic [PW_W-1:0] pw_cnt;
    logic            pos;
    logic            neg;
    logic            oe;
  } top_state_t;

  top_state_t s;
  top_state_t next_s;
  logic [1:0] rx_pos;
  logic [1:0] rx_neg;
  logic [1:0] rx_std;
  logic [1:0] clk8k;
  logic [1:0] los;
  logic [1:0] ami_ev;
  logic [1:0] no8;
  logic [1:0] no4;
  logic [1:0] viol_ev;
  logic [1:0] omit_ev;
  logic       tick;
  logic       align_v;
  logic       align_o;
  logic       tx_viol;
  logic [ACC_W:0] acc_sum;

  assign rx_pos = {cc_receive_pin_two_pos_in, cc_receive_pin_one_pos_in};
  assign rx_neg = {cc_receive_pin_two_neg_in, cc_receive_pin_one_neg_in};
  assign rx_std = {input_clock_two_in, input_clock_one_in};

  // ==========================================================================
  // receivers
  for (genvar c = 0; c < 2; c++) begin : g_rx
    cc_rx_chan #(
      .MISS8_CYC (CNT_W'(NO8_CYC)),
      .MISS4_CYC (CNT_W'(NO4_CYC))
    ) u_rx (
      .clk_in        (clk_in),
      .sys_rst_in    (sys_rst_in),
      .line_pos_in   (rx_pos[c]),
      .line_neg_in   (rx_neg[c]),
      .std_clock_in  (rx_std[c]),
      .fmt_in        (s.fmt[c]),
      .edge_sel_in   (recovered_edge_select_in),
      .single_bit_error_count_en_en_in  (single_bit_error_count_en_in),
      .ami_inv_en_in (ami_invalidate_en_in),
      .los_inv_en_in (los_invalidate_en_in),
      .clk8k_out     (clk8k[c]),
      .invalid_out   (clock_invalid_out[c]),
      .los_out       (los[c]),
      .ami_ev_out    (ami_ev[c]),
      .no8_out       (no8[c]),
      .no4_out       (no4[c]),
      .irreg_out     (irregularity_out[c]),
      .viol_ev_out   (viol_ev[c]),
      .omit_ev_out   (omit_ev[c])
    );
  end

  assign input_clock_one_out = clk8k[0];
  assign input_clock_two_out = clk8k[1];

  // reference alignment only from a CC-mode channel whose component is present
  always_comb begin
    align_v = 1'b0;
    align_o = 1'b0;
    if (reference_select_in == REF_ONE) begin
      align_v = ~s.fmt[0] & ~no8[0] & viol_ev[0];
      align_o = ~s.fmt[0] & ~no4[0] & omit_ev[0] & align_v;
    end else if (reference_select_in == REF_TWO) begin
      align_v = ~s.fmt[1] & ~no8[1] & viol_ev[1];
      align_o = ~s.fmt[1] & ~no4[1] & omit_ev[1] & align_v;
    end
  end

  // fractional divider: 64 ticks per 25000 clocks gives the exact 64kHz bit rate
  assign acc_sum = {1'b0, s.acc} + (ACC_W + 1)'(LINE_KHZ);
  assign tick    = (acc_sum >= (ACC_W + 1)'(CLK_KHZ)) | align_v;

  // ==========================================================================
  // next-state
  always_comb begin
    logic [2:0] cur;
    logic [4:0] fcur;
    next_s  = s;
    cur     = align_v ? VIOL_BIT : s.bit_idx;
    fcur    = align_o ? POST_OMIT : s.frame;
    tx_viol = 1'b0;
    // format bits reset to composite clock mode, loaded only on request
    if (chan_signal_format_load_in) begin
      next_s.fmt = chan_signal_format_in;
    end
    // sticky status: an event in the clear cycle wins over the clear
    next_s.la_stat = (s.la_stat & ~line_alarm_clear_in) | {ami_ev, los};
    next_s.cm_stat = (s.cm_stat & ~component_missing_clear_in) | {no4, no8};
    next_s.irq     = |((next_s.la_stat & line_alarm_irq_enable_in) |
                       (next_s.cm_stat & component_missing_irq_enable_in));
    // bit timing; alignment restarts the divider at the reference violation
    if (align_v) begin
      next_s.acc = '0;
    end else if (tick) begin
      next_s.acc = ACC_W'(acc_sum - (ACC_W + 1)'(CLK_KHZ));
    end else begin
      next_s.acc = acc_sum[ACC_W-1:0];
    end
    if (tick) begin
      // every bit is a mark; bit 0 repeats polarity unless suppressed or omitted
      tx_viol = (cur == VIOL_BIT) & ~cc_transmit_suppress_8k_in &
                ~(cc_transmit_400hz_enable_in & (fcur == OMIT_FRAME));
      next_s.pol     = tx_viol ? s.pol : ~s.pol;
      next_s.bit_idx = cur + 3'h1;
      if (cur == VIOL_BIT) begin
        next_s.frame = (fcur == LAST_FRAME) ? OMIT_FRAME : fcur + 5'h01;
      end
      next_s.pulse  = 1'b1;
      next_s.pw_cnt = '0;
    end else if (s.pulse) begin
      // pulse width from the duty select
      if (s.pw_cnt == (cc_transmit_duty_select_in ? PW_W'(PW58_CYC - 1) : PW_W'(PW50_CYC - 1))) begin
        next_s.pulse = 1'b0;
      end else begin
        next_s.pw_cnt = s.pw_cnt + PW_W'(1);
      end
    end
    // disabled drivers park both rails low and release the pair
    next_s.pos = cc_transmit_enable_in & next_s.pulse & next_s.pol;
    next_s.neg = cc_transmit_enable_in & next_s.pulse & ~next_s.pol;
    next_s.oe  = cc_transmit_enable_in;
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign chan_signal_format_out       = s.fmt;
  assign line_alarm_status_out        = s.la_stat;
  assign component_missing_status_out = s.cm_stat;
  assign interrupt_request_pin_out    = s.irq;
  assign cc_transmit_positive_out     = s.pos;
  assign cc_transmit_negative_out     = s.neg;
  assign cc_transmit_oe_out           = s.oe;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_irq_follows;
    |((s.la_stat & line_alarm_irq_enable_in) | (s.cm_stat & component_missing_irq_enable_in)) &&
      $stable(line_alarm_irq_enable_in) && $stable(component_missing_irq_enable_in) |-> s.irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("enabled status without interrupt");

  property p_set_beats_clear;
    ami_ev[0] |=> s.la_stat[LA_AMI];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) else $error("AMI event lost");

  property p_no8_sticky;
    no8[1] |=> s.cm_stat[CM_NO8 + 1];
  endproperty
  a_no8_sticky: assert property (p_no8_sticky) else $error("missing 8kHz not latched");

  property p_suppress_plain;
    tick && cc_transmit_suppress_8k_in |=> s.pol != $past(s.pol);
  endproperty
  a_suppress_plain: assert property (p_suppress_plain) else $error("violation sent while suppressed");

  property p_driver_off;
    !cc_transmit_enable_in |=> !s.pos && !s.neg && !s.oe;
  endproperty
  a_driver_off: assert property (p_driver_off) else $error("pair driven while disabled");

  property p_align_restart;
    align_v |=> s.bit_idx == 3'h1 && s.acc == '0;
  endproperty
  a_align_restart: assert property (p_align_restart) else $error("transmit not aligned");

  property p_rails_exclusive;
    !(s.pos && s.neg);
  endproperty
  a_rails_exclusive: assert property (p_rails_exclusive) else $error("both rails high");
endmodule

// ===== include/cc_pkg.sv
// constants, timing counts and helpers shared by the composite clock receivers and transmitter
// ============================================================================
// How it works
// - line is 64kHz AMI with a bipolar violation every eighth bit marking 8kHz
// - 400Hz variant drops the 8kHz violation at a 400Hz rate
// - after reset both channels start in composite clock mode
// - per-channel format bit: 0 is composite clock, 1 is logic-level clock
// - receiver forwards a recovered 8kHz clock, not the 64kHz line rate
// - edge select puts 8kHz falling edge on violation or on following pulse
// - loss of signal after 32us with no pulse on the line
// - AMI violation only after two consecutive broken eight-bit periods
// - loss and AMI set sticky status bits, enabled ones drive interrupt
// - with bit-error counting on, each broken period pulses the leaky bucket
// - AMI or loss can each invalidate the channel clock when enabled
// - no violation for 500us sets sticky missing-8kHz bit, always active
// - with 8kHz missing in composite clock mode, no recovered clock is forwarded
// - no omitted violation for 5ms sets sticky missing-400Hz bit
// - with 8kHz missing, AMI status keeps getting set
// - missing 400Hz neither sets AMI status nor invalidates the clock
// - transmitter drives positive/negative pair gated by an enable bit
// - duty select gives 50% or 5/8 of the bit period
// - suppress-8kHz sends plain AMI with no violations
// - transmit violations align to a CC reference channel with 8kHz present
// - 400Hz enable omits one violation every 160 bits
// - 400Hz aligns to the reference omission, else divides own 8kHz
// - with 8kHz suppressed the 400Hz enable has no effect
package cc_pkg;
  // ==========================================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int CLK_KHZ       = 25000;
  localparam int LINE_KHZ      = 64;
  localparam int LOS_NS        = 32000;
  localparam int LOS_CYC       = (LOS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NO8_NS        = 500000;
  localparam int NO8_DEF_CYC   = (NO8_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NO4_NS        = 5000000;
  localparam int NO4_DEF_CYC   = (NO4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FRAME_NS      = 125000;
  localparam int PW50_CYC      = FRAME_NS / 16 / CLK_PERIOD_NS;
  localparam int PW58_CYC      = FRAME_NS * 5 / 64 / CLK_PERIOD_NS;
  // ==========================================================================
  // widths and line pattern
  localparam int CNT_W   = 17;
  localparam int ACC_W   = 15;
  localparam int PW_W    = 9;
  localparam logic [4:0] GOOD_MARKS = 5'h07;
  localparam logic [4:0] OMIT_MARKS = 5'h0F;
  localparam logic [2:0] VIOL_BIT   = 3'h0;
  localparam logic [4:0] LAST_FRAME = 5'h13;
  localparam logic [4:0] OMIT_FRAME = 5'h00;
  localparam logic [4:0] POST_OMIT  = 5'h01;
  localparam logic [4:0] RISE_MARK  = 5'h03; // marks counted before the one that raises the 8kHz clock
  // ==========================================================================
  // reference select codes and status bit positions
  localparam logic [1:0] REF_ONE = 2'h1;
  localparam logic [1:0] REF_TWO = 2'h2;
  localparam int LA_LOS = 0;
  localparam int LA_AMI = 2;
  localparam int CM_NO8 = 0;
  localparam int CM_NO4 = 2;

  // saturating step of a timeout counter
  function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] lim);
    cnt_step = (cnt == lim) ? cnt : cnt + CNT_W'(1);
  endfunction
endpackage

// ===== logic/cc_rx_chan.sv
// one composite clock receiver channel: decode, alarms and recovered 8kHz clock
`timescale 1ns/10ps
module cc_rx_chan import cc_pkg::*; #(
  parameter logic [CNT_W-1:0] MISS8_CYC = CNT_W'(NO8_DEF_CYC),
  parameter logic [CNT_W-1:0] MISS4_CYC = CNT_W'(NO4_DEF_CYC)
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  // line and logic-level pins, asynchronous
  input  wire logic line_pos_in,
  input  wire logic line_neg_in,
  input  wire logic std_clock_in,
  // configuration
  input  wire logic fmt_in,
  input  wire logic edge_sel_in,
  input  wire logic single_bit_error_count_en_en_in,
  input  wire logic ami_inv_en_in,
  input  wire logic los_inv_en_in,
  // results
  output logic      clk8k_out,
  output logic      invalid_out,
  output logic      los_out,
  output logic      ami_ev_out,
  output logic      no8_out,
  output logic      no4_out,
  output logic      irreg_out,
  output logic      viol_ev_out,
  output logic      omit_ev_out
);
  typedef struct packed {
    logic             pos_s1, pos_s2, neg_s1, neg_s2, std_s1, std_s2, pos_d, neg_d;
    logic             last_pol, have_mark, pend, bad_prev, clk_gen;
    logic [4:0]       marks;
    logic [CNT_W-1:0] los_cnt, v_cnt, o_cnt;
    logic             los, no8, no4, ami_act, clk_out, invalid;
    logic             ami_ev, irreg, viol_ev, omit_ev;
  } rx_state_t;

  rx_state_t s;
  rx_state_t next_s;
  logic      mark;
  logic      viol;
  logic      pend_bad;

  // marks start on a rising level of either rail; a repeat of polarity is a violation
  assign mark = (s.pos_s2 & ~s.pos_d) | (s.neg_s2 & ~s.neg_d);
  assign viol = mark & s.have_mark & (s.pos_s2 == s.last_pol);

  // ==========================================================================
  // next-state
  always_comb begin
    next_s         = s;
    pend_bad       = 1'b0;
    next_s.pos_s1  = line_pos_in;
    next_s.pos_s2  = s.pos_s1;
    next_s.neg_s1  = line_neg_in;
    next_s.neg_s2  = s.neg_s1;
    next_s.std_s1  = std_clock_in;
    next_s.std_s2  = s.std_s1;
    next_s.pos_d   = s.pos_s2;
    next_s.neg_d   = s.neg_s2;
    next_s.ami_ev  = 1'b0;
    next_s.irreg   = 1'b0;
    next_s.viol_ev = 1'b0;
    next_s.omit_ev = 1'b0;
    if (mark) begin
      next_s.have_mark = 1'b1;
      next_s.last_pol  = s.pos_s2;
    end
    // loss of signal: timer restarted by every pulse
    if (mark) begin
      next_s.los_cnt = '0;
      next_s.los     = 1'b0;
    end else begin
      next_s.los_cnt = cnt_step(s.los_cnt, CNT_W'(LOS_CYC));
      next_s.los     = (s.los_cnt == CNT_W'(LOS_CYC - 1)) | s.los;
    end
    // eight-bit period checks; a run of 15 marks then a violation is a 400Hz omission
    if (viol) begin
      next_s.marks   = '0;
      next_s.viol_ev = 1'b1;
      if (s.marks == OMIT_MARKS) begin
        next_s.omit_ev = 1'b1;
      end else if (s.marks != GOOD_MARKS) begin
        pend_bad = 1'b1;
      end
    end else if (mark) begin
      if (s.marks == OMIT_MARKS) begin
        pend_bad     = 1'b1;
        next_s.marks = '0;
      end else begin
        next_s.marks = s.marks + 5'h01;
      end
    end
    if (viol | (mark & (s.marks == OMIT_MARKS))) begin
      next_s.bad_prev = pend_bad;
      next_s.irreg    = pend_bad & single_bit_error_count_en_en_in;
      if (pend_bad & s.bad_prev) begin
        next_s.ami_ev  = 1'b1;
        next_s.ami_act = 1'b1;
      end else if (!pend_bad) begin
        next_s.ami_act = 1'b0;
      end
    end
    // missing component timers, restarted at each violation or omission
    if (viol) begin
      next_s.v_cnt = '0;
      next_s.no8   = 1'b0;
    end else begin
      next_s.v_cnt = cnt_step(s.v_cnt, MISS8_CYC);
      next_s.no8   = (s.v_cnt == MISS8_CYC - CNT_W'(1)) | s.no8;
    end
    if (viol & (s.marks == OMIT_MARKS)) begin
      next_s.o_cnt = '0;
      next_s.no4   = 1'b0;
    end else begin
      next_s.o_cnt = cnt_step(s.o_cnt, MISS4_CYC);
      next_s.no4   = (s.o_cnt == MISS4_CYC - CNT_W'(1)) | s.no4;
    end
    // recovered 8kHz: falling edge on violation or on the pulse after it
    if (viol) begin
      next_s.pend = edge_sel_in;
    end else if (mark) begin
      next_s.pend = 1'b0;
    end
    if (edge_sel_in ? (mark & ~viol & s.pend) : viol) begin
      next_s.clk_gen = 1'b0;
    end else if (mark & ~viol & (s.marks == RISE_MARK)) begin
      // rise counted in line bits, so the recovered clock follows the line rate, not a fixed timer
      next_s.clk_gen = 1'b1;
    end
    // in composite clock mode, held low while 8kHz is absent so the monitor sees the clock stop
    next_s.clk_out = fmt_in ? s.std_s2 : (s.clk_gen & ~s.no8);
    // a missing 400Hz is not a reason to invalidate
    next_s.invalid = ~fmt_in & ((ami_inv_en_in & s.ami_act) | (los_inv_en_in & s.los));
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign clk8k_out   = s.clk_out;
  assign invalid_out = s.invalid;
  assign los_out     = s.los;
  assign ami_ev_out  = s.ami_ev;
  assign no8_out     = s.no8;
  assign no4_out     = s.no4;
  assign irreg_out   = s.irreg;
  assign viol_ev_out = s.viol_ev;
  assign omit_ev_out = s.omit_ev;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_los_timeout;
    (s.los_cnt == CNT_W'(LOS_CYC - 1)) && !mark |=> s.los;
  endproperty
  a_los_timeout: assert property (p_los_timeout) else $error("loss of signal not declared");

  property p_no8_timeout;
    (s.v_cnt == MISS8_CYC - CNT_W'(1)) && !viol |=> s.no8;
  endproperty
  a_no8_timeout: assert property (p_no8_timeout) else $error("missing 8kHz not declared");

  property p_no8_clock_stops;
    s.no8 && !fmt_in |=> !s.clk_out;
  endproperty
  a_no8_clock_stops: assert property (p_no8_clock_stops) else $error("clock forwarded without 8kHz");

  property p_ami_two_bad;
    s.ami_ev |-> $past(pend_bad) && $past(s.bad_prev);
  endproperty
  a_ami_two_bad: assert property (p_ami_two_bad) else $error("AMI violation without two bad periods");

  property p_irreg_gated;
    s.irreg |-> $past(single_bit_error_count_en_en_in) && $past(pend_bad);
  endproperty
  a_irreg_gated: assert property (p_irreg_gated) else $error("irregularity without enable");

  property p_los_invalid;
    s.los && los_inv_en_in && !fmt_in |=> s.invalid;
  endproperty
  a_los_invalid: assert property (p_los_invalid) else $error("loss did not invalidate");
endmodule

// ===== tb/cc_line_model.sv
// far-end composite clock source driving one receive line pair
`timescale 1ns/10ps
module cc_line_model #(
  parameter int BIT_NS = 320
) (
  // 0 silent, 1 cc with 400hz omission, 2 cc only, 3 plain ami
  input  wire logic [1:0] mode_in,
  // line rails, high while a mark of that sign is sent
  output logic            pos_out,
  output logic            neg_out
);
  int   bitn;
  int   frame;
  logic last;
  logic viol;

  // ==========================================================
  // line encoder, all ones with return to zero each half bit
  initial begin
    pos_out = 1'b0;
    neg_out = 1'b0;
    bitn = 0;
    frame = 0;
    last = 1'b0;
    #7;
    forever begin
      viol = (bitn == 0) && (mode_in != 2'h3) && !(mode_in == 2'h1 && frame == 0);
      if (mode_in != 2'h0) begin
        // a violation repeats the last sign, every other mark flips it
        if (!viol)
          last = ~last;
        pos_out = last;
        neg_out = ~last;
      end
      #(BIT_NS / 2);
      pos_out = 1'b0;
      neg_out = 1'b0;
      #(BIT_NS / 2);
      bitn = (bitn + 1) % 8;
      if (bitn == 0)
        frame = (frame + 1) % 20;
    end
  end
endmodule

// ===== tb/composite_clock_rx_tx_tb.sv
// self-checking bench for the composite clock receivers and transmitter
`timescale 1ns/10ps
module composite_clock_rx_tx_tb import cc_pkg::*;;
  logic clk_in = 0, sys_rst_in = 1, input_clock_one_in = 0, input_clock_two_in = 0;
  logic cc_receive_pin_one_pos_in, cc_receive_pin_one_neg_in, cc_receive_pin_two_pos_in, cc_receive_pin_two_neg_in;
  logic [1:0] chan_signal_format_in = 0, reference_select_in = 0, m1 = 0, m2 = 0;
  logic chan_signal_format_load_in = 0, recovered_edge_select_in = 0, single_bit_error_count_en_in = 0;
  logic ami_invalidate_en_in = 0, los_invalidate_en_in = 0, cc_transmit_enable_in = 0;
  logic cc_transmit_duty_select_in = 0, cc_transmit_suppress_8k_in = 0, cc_transmit_400hz_enable_in = 0;
  logic [3:0] line_alarm_clear_in = 0, line_alarm_irq_enable_in = 0;
  logic [3:0] component_missing_clear_in = 0, component_missing_irq_enable_in = 0;
  logic [1:0] chan_signal_format_out, clock_invalid_out, irregularity_out;
  logic [3:0] line_alarm_status_out, component_missing_status_out;
  logic input_clock_one_out, input_clock_two_out, interrupt_request_pin_out;
  logic cc_transmit_positive_out, cc_transmit_negative_out, cc_transmit_oe_out;
  int bad_count = 0, num_checks = 0, w, v, n = 0;

  // ==========================================================
  // clock, design and far-end sources
  initial forever #20 clk_in = ~clk_in;
  // small timeouts keep the run short
  composite_clock_rx_tx #(.NO8_CYC(200), .NO4_CYC(3000)) dut (.*);
  cc_line_model u_far1 (.mode_in(m1), .pos_out(cc_receive_pin_one_pos_in), .neg_out(cc_receive_pin_one_neg_in));
  cc_line_model u_far2 (.mode_in(m2), .pos_out(cc_receive_pin_two_pos_in), .neg_out(cc_receive_pin_two_neg_in));
  // irregularity pulses on channel one
  always @(posedge clk_in) if (irregularity_out[0] === 1'b1) n++;

  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // pulse one cycle of both clear strobes
  task automatic clr(input logic [3:0] la, input logic [3:0] cm);
    line_alarm_clear_in = la;
    component_missing_clear_in = cm;
    tick(1);
    line_alarm_clear_in = 0;
    component_missing_clear_in = 0;
  endtask
  // wait for channel two recovered clock to reach a level; t counts the cycles waited
  task automatic wait_clk2(input logic lv, output int t);
    t = 0;
    while (input_clock_two_out !== lv && t < 200) begin
      tick(1);
      t++;
    end
    if (t == 200) begin
      bad_count++;
      $display("[ERR] %0t recovered clock stuck", $time);
      finish_test();
    end
  endtask
  // watch 17 transmit pulses: width of the last, count of repeated signs
  task automatic tx(output int wd, output int vc);
    int k, t;
    logic p, q;
    vc = 0;
    for (k = 0; k < 17; k++) begin
      t = 0;
      while (!(cc_transmit_positive_out | cc_transmit_negative_out) && t < 1000) begin
        tick(1);
        t++;
      end
      if (t == 1000) begin
        bad_count++;
        $display("[ERR] %0t no transmit pulse", $time);
        finish_test();
      end
      q = cc_transmit_positive_out;
      wd = 0;
      while ((cc_transmit_positive_out | cc_transmit_negative_out) && wd < 1000) begin
        tick(1);
        wd++;
      end
      if (k > 0 && q == p) vc++;
      p = q;
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    tick(10);
    sys_rst_in = 0;
    tick(2);
    chk(chan_signal_format_out, 0);
    chk(component_missing_status_out, 0);
    // good lines, channel two has no 400hz marker
    m1 = 1;
    m2 = 2;
    single_bit_error_count_en_in = 1;
    tick(6000);
    clr(4'hF, 4'hF);
    n = 0;
    tick(4000);
    chk(line_alarm_status_out, 0);
    chk(component_missing_status_out, 4'h8);
    chk(clock_invalid_out, 0);
    chk(n == 0, 1);
    // recovered clock low from violation to fourth mark: 4 bits of 8 cycles
    wait_clk2(1'b1, w);
    wait_clk2(1'b0, w);
    wait_clk2(1'b1, w);
    chk(w == 32, 1);
    // falling edge moved to the pulse after the violation: one bit less low
    recovered_edge_select_in = 1;
    wait_clk2(1'b0, w);
    wait_clk2(1'b1, w);
    wait_clk2(1'b0, w);
    wait_clk2(1'b1, w);
    chk(w == 24, 1);
    // plain ami, no violations at all
    m1 = 3;
    ami_invalidate_en_in = 1;
    line_alarm_irq_enable_in = 4'h4;
    tick(600);
    chk(component_missing_status_out[0], 1);
    chk(line_alarm_status_out[2], 1);
    chk(clock_invalid_out[0], 1);
    chk(interrupt_request_pin_out, 1);
    chk(input_clock_one_out, 0);
    chk(n > 0, 1);
    clr(4'h4, 0);
    tick(300);
    chk(line_alarm_status_out[2], 1);
    // silent line
    m1 = 0;
    ami_invalidate_en_in = 0;
    los_invalidate_en_in = 1;
    line_alarm_irq_enable_in = 4'h1;
    clr(4'hF, 0);
    tick(700);
    chk(line_alarm_status_out[0], 0);
    tick(300);
    chk(line_alarm_status_out[0], 1);
    chk(clock_invalid_out[0], 1);
    chk(interrupt_request_pin_out, 1);
    line_alarm_irq_enable_in = 0;
    tick(3);
    chk(interrupt_request_pin_out, 0);
    // channel one to logic-level clock
    chan_signal_format_in = 2'h1;
    chan_signal_format_load_in = 1;
    tick(1);
    chan_signal_format_load_in = 0;
    tick(2);
    chk(chan_signal_format_out, 1);
    // transmitter, free running without a reference
    cc_transmit_enable_in = 1;
    tick(2);
    chk(cc_transmit_oe_out, 1);
    tx(w, v);
    chk(w == 195, 1);
    chk(v, 2);
    cc_transmit_duty_select_in = 1;
    tx(w, v);
    chk(w == 244, 1);
    cc_transmit_suppress_8k_in = 1;
    cc_transmit_400hz_enable_in = 1;
    tx(w, v);
    chk(v, 0);
    // channel two as reference: each aligned bit flips the sign at the violation of the input
    recovered_edge_select_in = 0;
    reference_select_in = 2'h2;
    wait_clk2(1'b1, w);
    wait_clk2(1'b0, w);
    v = cc_transmit_positive_out;
    w = 0;
    while (cc_transmit_positive_out == v && w < 200) begin
      tick(1);
      w++;
    end
    chk(w == 64, 1);
    cc_transmit_enable_in = 0;
    tick(2);
    chk(cc_transmit_oe_out, 0);
    finish_test();
  end
endmodule
